// >>> hdl/acci_pkg.sv
// Shared constants, instruction and memory carriers for the security instruction unit.
package acci_pkg;

	// ==========================================================================
	// Memory and slot geometry
	// ==========================================================================
	localparam int unsigned ADDR_W = 12; // Width of an internal memory byte address.
	localparam logic [12:0] RAM_END = 13'h1000; // First byte address past the usable memory.
	localparam logic [3:0] SLOT_SHIFT = 4'h4; // Key and counter slots are sixteen bytes apart.
	localparam logic [4:0] BLK_BYTES = 5'h10; // Bytes in one cipher block.
	localparam logic [3:0] LAST_BYTE = 4'hf; // Index of the last byte inside a block.

	// ==========================================================================
	// Authentication mode operand fields
	// ==========================================================================
	localparam int unsigned MODE_NOPREFIX_BIT = 2; // Set to drop the length prefix.
	localparam logic [7:0] PREFIX_LEN = 8'h02; // Length prefix bytes: a zero, then the count.
	localparam logic [7:0] PREFIX_HI = 8'h00; // Upper prefix byte, always zero.

	// ==========================================================================
	// Memory read timing
	// ==========================================================================
	localparam logic [1:0] PH_ISSUE = 2'h0; // Address is driven to the memory.
	localparam logic [1:0] PH_CAPTURE = 2'h2; // Read data is valid at this phase.

	// Instruction opcodes accepted by the unit.
	typedef enum logic [1:0] {
		OP_CTR = 2'h0,
		OP_COUNTER_DECRYPT = 2'h1,
		OP_MAC = 2'h2
	} acci_op_e;

	// One instruction as issued by the host.
	typedef struct packed {
		acci_op_e op; // Operation to run.
		logic prio; // Zero is low priority, one is high priority.
		logic [7:0] key_idx; // Key slot index.
		logic [6:0] count; // Number of payload bytes.
		logic [7:0] ctr_idx; // Counter slot index.
		logic [11:0] src; // Payload start address.
		logic [11:0] dst; // Output start address, zero selects the default.
		logic [2:0] mode; // Authentication mode.
	} acci_instr_s;

	// One request to the internal memory.
	typedef struct packed {
		logic en; // Access strobe.
		logic we; // High for a write.
		logic [11:0] addr; // Byte address.
		logic [7:0] wdata; // Write data.
	} acci_mem_req_s;

endpackage : acci_pkg

// >>> hdl/acci_slot.sv
// One priority slot: holds a waiting instruction and reports its events.
`timescale 1ns/1ns
`default_nettype none

module acci_slot
	import acci_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic accept_i,
	input wire acci_instr_s instr_i,
	input wire logic start_i,
	input wire logic finish_i,
	output logic pending_o,
	output acci_instr_s instr_o,
	output logic busy_err_o,
	output logic done_o
);

	// ==========================================================================
	// Slot state
	// ==========================================================================
	logic busy_q; // High from acceptance until the engine finishes the instruction.
	logic free; // The slot can take a new instruction this cycle.

	// A slot that finishes in this very cycle is already free for the next one.
	assign free = !busy_q || finish_i;

	// Busy and pending flags; a new acceptance wins over the finish clear.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			busy_q <= 1'b0;
			pending_o <= 1'b0;
		end
		else if (accept_i && free)
		begin
			busy_q <= 1'b1;
			pending_o <= 1'b1;
		end
		else
		begin
			if (finish_i)
				busy_q <= 1'b0;
			if (start_i)
				pending_o <= 1'b0;
		end
	end

	// Captures the operands of an accepted instruction.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			instr_o <= '0;
		else if (accept_i && free)
			instr_o <= instr_i;
	end

	// Error and completion pulses, one cycle each.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			busy_err_o <= 1'b0;
			done_o <= 1'b0;
		end
		else
		begin
			busy_err_o <= accept_i && !free;
			done_o <= finish_i;
		end
	end

endmodule : acci_slot

`default_nettype wire

// >>> hdl/acci_unit.sv
// Counter mode and CBC-MAC instruction engine working on the internal memory.
`timescale 1ns/1ns
`default_nettype none

module acci_unit
	import acci_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire acci_instr_s instr_i,
	output acci_mem_req_s mem_o,
	input wire logic [7:0] mem_rdata_i,
	output logic aes_start_o,
	output logic [127:0] aes_key_o,
	output logic [127:0] aes_din_o,
	input wire logic aes_done_i,
	input wire logic [127:0] aes_result_i,
	output logic priority_slot_busy_error_lo_o,
	output logic priority_slot_busy_error_hi_o,
	output logic low_prio_done_event_o,
	output logic high_prio_done_event_o,
	output logic memory_range_error_o
);

	// ==========================================================================
	// Helper functions
	// ==========================================================================

	// True when a range of bytes lies wholly inside the memory.
	function automatic logic fits(input logic [12:0] base, input logic [8:0] len);
		logic [13:0] last;
		last = 14'(base) + 14'(len);
		return last <= 14'(RAM_END);
	endfunction : fits

	// Byte address of an operand plus an offset.
	function automatic logic [11:0] at(input logic [11:0] base, input logic [7:0] off);
		return 12'(base + 12'(off));
	endfunction : at

	// Start of a sixteen-byte key or counter slot.
	function automatic logic [12:0] slot(input logic [7:0] idx);
		return 13'(idx) << SLOT_SHIFT;
	endfunction : slot

	// ==========================================================================
	// Engine state
	// ==========================================================================
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_CHECK = 9'h002,
		ST_LDKEY = 9'h004,
		ST_LDCTR = 9'h008,
		ST_FILL = 9'h010,
		ST_AES = 9'h020,
		ST_XOR = 9'h040,
		ST_OUT = 9'h080,
		ST_FINISH = 9'h100
	} acci_state_e;

	acci_state_e state_q; // Current engine state.
	acci_instr_s cur_q; // Instruction being executed.
	logic [11:0] dst_q; // Resolved output address.
	logic [4:0] out_len_q; // Authentication code length in bytes.
	logic [127:0] ctr_q; // Counter block, low sixteen bits step per block.
	logic [127:0] ks_q; // Key stream or code, consumed from the top byte.
	logic [127:0] blk_q; // Block being gathered for authentication.
	logic [3:0] idx_q; // Byte index inside the current block.
	logic [7:0] pos_q; // Position in the byte stream.
	logic [1:0] ph_q; // Memory access phase.
	logic range_bad; // Some operand range leaves the memory.
	logic [11:0] dst_res; // Output address after the zero default.
	logic is_mac; // Current instruction authenticates.
	logic [7:0] pre_len; // Prefix bytes in the stream.
	logic [7:0] strm_len; // Prefix plus payload bytes.
	logic need_mem; // The current fill byte comes from memory.
	logic [7:0] fill_byte; // Next byte of the authenticated stream.
	logic [11:0] rd_addr; // Address to read in the current state.
	logic byte_ok; // The current byte is available this cycle.

	// Slot interface.
	logic take_lo; // Engine starts the low slot.
	logic take_hi; // Engine starts the high slot.
	logic pend_lo; // Low slot holds a waiting instruction.
	logic pend_hi; // High slot holds a waiting instruction.
	acci_instr_s ins_lo; // Low slot operands.
	acci_instr_s ins_hi; // High slot operands.
	logic fin; // Engine finishes the current instruction.

	// ==========================================================================
	// Priority slots
	// ==========================================================================
	acci_slot u_slot_lo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.accept_i(instr_valid_i && !instr_i.prio),
		.instr_i(instr_i),
		.start_i(take_lo),
		.finish_i(fin && !cur_q.prio),
		.pending_o(pend_lo),
		.instr_o(ins_lo),
		.busy_err_o(priority_slot_busy_error_lo_o),
		.done_o(low_prio_done_event_o)
	);

	acci_slot u_slot_hi (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.accept_i(instr_valid_i && instr_i.prio),
		.instr_i(instr_i),
		.start_i(take_hi),
		.finish_i(fin && cur_q.prio),
		.pending_o(pend_hi),
		.instr_o(ins_hi),
		.busy_err_o(priority_slot_busy_error_hi_o),
		.done_o(high_prio_done_event_o)
	);

	// High priority work is started first when both slots wait.
	assign take_hi = (state_q == ST_IDLE) && pend_hi;
	assign take_lo = (state_q == ST_IDLE) && pend_lo && !pend_hi;
	assign fin = (state_q == ST_FINISH);

	// ==========================================================================
	// Operand decode
	// ==========================================================================

	// Resolves the destination, stream length and the memory range check.
	always_comb
	begin
		is_mac = (cur_q.op == OP_MAC);
		if (cur_q.dst != 12'h000)
			dst_res = cur_q.dst;
		else if (is_mac)
			dst_res = at(cur_q.src, {1'b0, cur_q.count});
		else
			dst_res = cur_q.src;
		pre_len = cur_q.mode[MODE_NOPREFIX_BIT] ? 8'h00 : PREFIX_LEN;
		strm_len = 8'({1'b0, cur_q.count} + pre_len);
		// Key, payload and output must all sit inside the memory.
		range_bad = !fits(slot(cur_q.key_idx), 9'(BLK_BYTES))
			|| !fits(13'(cur_q.src), 9'(cur_q.count))
			|| (!is_mac && !fits(slot(cur_q.ctr_idx), 9'(BLK_BYTES)))
			|| (!is_mac && !fits(13'(dst_res), 9'(cur_q.count)))
			|| (is_mac && !fits(13'(dst_res), 9'(out_len_q)));
	end

	// Picks the read address and the next authenticated byte.
	always_comb
	begin
		need_mem = 1'b0;
		fill_byte = 8'h00;
		rd_addr = at(cur_q.src, pos_q);
		if (state_q == ST_LDKEY)
			rd_addr = 12'(slot(cur_q.key_idx) + 13'(idx_q));
		else if (state_q == ST_LDCTR)
			rd_addr = 12'(slot(cur_q.ctr_idx) + 13'(idx_q));
		else if (state_q == ST_FILL)
		begin
			if (pos_q < pre_len)
				fill_byte = (pos_q == 8'h00) ? PREFIX_HI : {1'b0, cur_q.count};
			else if (pos_q < strm_len)
			begin
				need_mem = 1'b1;
				fill_byte = mem_rdata_i;
				rd_addr = at(cur_q.src, 8'(pos_q - pre_len));
			end
		end
		byte_ok = !need_mem || (ph_q == PH_CAPTURE);
	end

	// ==========================================================================
	// Sequencer
	// ==========================================================================

	// Steps through key load, counter load, cipher runs and byte moves.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= ST_IDLE;
			cur_q <= '0;
			dst_q <= 12'h000;
			out_len_q <= 5'h00;
			aes_key_o <= '0;
			ctr_q <= '0;
			ks_q <= '0;
			blk_q <= '0;
			aes_din_o <= '0;
			aes_start_o <= 1'b0;
			idx_q <= 4'h0;
			pos_q <= 8'h00;
			ph_q <= PH_ISSUE;
			mem_o <= '0;
			memory_range_error_o <= 1'b0;
		end
		else
		begin
			mem_o <= '0;
			aes_start_o <= 1'b0;
			memory_range_error_o <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					idx_q <= 4'h0;
					pos_q <= 8'h00;
					ph_q <= PH_ISSUE;
					// An authentication chain must start from zero, not from a leftover key stream.
					ks_q <= '0;
					if (take_hi || take_lo)
					begin
						cur_q <= take_hi ? ins_hi : ins_lo;
						state_q <= ST_CHECK;
					end
				end
				ST_CHECK:
				begin
					// Code length 4, 8 or 16 bytes, none when mode bits 1:0 are zero.
					out_len_q <= (cur_q.mode[1:0] == 2'h0) ? 5'h00 : 5'(5'h02 << cur_q.mode[1:0]);
					dst_q <= dst_res;
					if (cur_q.mode[1:0] != 2'h0 || !is_mac)
						state_q <= ST_LDKEY;
					else
						state_q <= ST_LDKEY;
				end
				ST_LDKEY, ST_LDCTR:
				begin
					if (ph_q == PH_ISSUE && range_bad)
					begin
						memory_range_error_o <= 1'b1;
						state_q <= ST_FINISH;
					end
					else if (ph_q == PH_ISSUE)
					begin
						mem_o <= '{en: 1'b1, we: 1'b0, addr: rd_addr, wdata: 8'h00};
						ph_q <= ph_q + 2'h1;
					end
					else if (ph_q != PH_CAPTURE)
						ph_q <= ph_q + 2'h1;
					else
					begin
						ph_q <= PH_ISSUE;
						idx_q <= idx_q + 4'h1;
						if (state_q == ST_LDKEY)
							aes_key_o <= {aes_key_o[119:0], mem_rdata_i};
						else
							ctr_q <= {ctr_q[119:0], mem_rdata_i};
						if (idx_q == LAST_BYTE && state_q == ST_LDKEY)
							state_q <= is_mac ? ST_FILL : ST_LDCTR;
						else if (idx_q == LAST_BYTE)
						begin
							// The first key stream block uses the counter as stored.
							aes_din_o <= {ctr_q[119:0], mem_rdata_i};
							aes_start_o <= (cur_q.count != 7'h00);
							ks_q <= '0;
							state_q <= (cur_q.count != 7'h00) ? ST_AES : ST_FINISH;
						end
					end
				end
				ST_FILL:
				begin
					if (need_mem && ph_q == PH_ISSUE)
						mem_o <= '{en: 1'b1, we: 1'b0, addr: rd_addr, wdata: 8'h00};
					if (!byte_ok)
						ph_q <= ph_q + 2'h1;
					else
					begin
						ph_q <= PH_ISSUE;
						blk_q <= {blk_q[119:0], fill_byte};
						idx_q <= idx_q + 4'h1;
						if (pos_q < strm_len)
							pos_q <= pos_q + 8'h01;
						if (idx_q == LAST_BYTE)
						begin
							// Chains the gathered block into the running code.
							aes_din_o <= ks_q ^ {blk_q[119:0], fill_byte};
							aes_start_o <= 1'b1;
							state_q <= ST_AES;
						end
					end
				end
				ST_AES:
				begin
					if (aes_done_i)
					begin
						ks_q <= aes_result_i;
						idx_q <= 4'h0;
						if (!is_mac)
							state_q <= ST_XOR;
						else if (pos_q >= strm_len)
						begin
							pos_q <= 8'h00;
							state_q <= (out_len_q != 5'h00) ? ST_OUT : ST_FINISH;
						end
						else
							state_q <= ST_FILL;
					end
				end
				ST_XOR:
				begin
					if (ph_q == PH_ISSUE)
						mem_o <= '{en: 1'b1, we: 1'b0, addr: rd_addr, wdata: 8'h00};
					if (ph_q != PH_CAPTURE)
						ph_q <= ph_q + 2'h1;
					else
					begin
						// Same transform for both directions of counter mode.
						mem_o <= '{en: 1'b1, we: 1'b1, addr: at(dst_q, pos_q),
							wdata: mem_rdata_i ^ ks_q[127:120]};
						ph_q <= PH_ISSUE;
						ks_q <= {ks_q[119:0], 8'h00};
						idx_q <= idx_q + 4'h1;
						pos_q <= pos_q + 8'h01;
						if (pos_q + 8'h01 == {1'b0, cur_q.count})
							state_q <= ST_FINISH;
						else if (idx_q == LAST_BYTE)
						begin
							aes_din_o <= {ctr_q[127:16], 16'(ctr_q[15:0] + 16'h0001)};
							ctr_q <= {ctr_q[127:16], 16'(ctr_q[15:0] + 16'h0001)};
							aes_start_o <= 1'b1;
							state_q <= ST_AES;
						end
					end
				end
				ST_OUT:
				begin
					// Writes the leading bytes of the code, one per cycle.
					mem_o <= '{en: 1'b1, we: 1'b1, addr: at(dst_q, pos_q), wdata: ks_q[127:120]};
					ks_q <= {ks_q[119:0], 8'h00};
					pos_q <= pos_q + 8'h01;
					if (pos_q + 8'h01 == 8'(out_len_q))
						state_q <= ST_FINISH;
				end
				ST_FINISH:
				begin
					state_q <= ST_IDLE;
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule : acci_unit

`default_nettype wire

// >>> sim/acci_unit_checker.sv
// Assertion checker that watches the ports of the security instruction engine.
`timescale 1ns/1ns
`default_nettype none

module acci_unit_checker
	import acci_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire acci_instr_s instr_i,
	input wire acci_mem_req_s mem_o,
	input wire logic aes_start_o,
	input wire logic [127:0] aes_key_o,
	input wire logic [127:0] aes_din_o,
	input wire logic aes_done_i,
	input wire logic priority_slot_busy_error_lo_o,
	input wire logic priority_slot_busy_error_hi_o,
	input wire logic low_prio_done_event_o,
	input wire logic high_prio_done_event_o,
	input wire logic memory_range_error_o
);
	logic in_flight_q; // A cipher block has been started and not yet answered.

	// Tracks the cipher core from its start pulse until its done pulse.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			in_flight_q <= 1'b0;
		else if (aes_start_o)
			in_flight_q <= 1'b1;
		else if (aes_done_i)
			in_flight_q <= 1'b0;
	end

	// ==========================================================================
	// Port properties
	// ==========================================================================
	// Every check runs on the one clock and is quiet during reset.
	default clocking cb_main @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_busy_lo;
		priority_slot_busy_error_lo_o |-> $past(instr_valid_i) && !$past(instr_i.prio);
	endproperty
	a_busy_lo: assert property (p_busy_lo) else $error("low busy error without a low request");
	property p_busy_hi;
		priority_slot_busy_error_hi_o |-> $past(instr_valid_i) && $past(instr_i.prio);
	endproperty
	a_busy_hi: assert property (p_busy_hi) else $error("high busy error without a high request");
	property p_range_done;
		memory_range_error_o |-> ##1 (low_prio_done_event_o || high_prio_done_event_o);
	endproperty
	a_range_done: assert property (p_range_done) else $error("no completion after range error");
	property p_range_nowr;
		memory_range_error_o |-> !(mem_o.en && mem_o.we) [*3];
	endproperty
	a_range_nowr: assert property (p_range_nowr) else $error("write after range error");
	property p_err_pulse;
		memory_range_error_o |=> !memory_range_error_o;
	endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("range error longer than one cycle");
	property p_done_pulse;
		low_prio_done_event_o |=> !low_prio_done_event_o && !high_prio_done_event_o;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("completion event repeated");
	property p_read_gap;
		mem_o.en && !mem_o.we |=> !mem_o.en;
	endproperty
	a_read_gap: assert property (p_read_gap) else $error("access while read data pending");
	property p_aes_hold;
		in_flight_q |-> $stable(aes_key_o) && $stable(aes_din_o);
	endproperty
	a_aes_hold: assert property (p_aes_hold) else $error("cipher operands moved while the core works");
endmodule : acci_unit_checker

`default_nettype wire

// >>> sim/acci_mem_model.sv
// Behavioural internal memory and cipher core facing the engine.
`timescale 1ns/1ns
`default_nettype none

module acci_mem_model
	import acci_pkg::*;
(
	input wire logic clk_i,
	input wire acci_mem_req_s mem_i,
	output logic [7:0] rdata_o,
	input wire logic start_i,
	input wire logic [127:0] key_i,
	input wire logic [127:0] din_i,
	input wire logic [3:0] lat_i,
	output logic done_o,
	output logic [127:0] result_o
);
	logic [7:0] mem [0:4095]; // Byte memory, preloaded by the bench.
	logic [3:0] cnt_q = 4'h0; // Cycles left until the cipher answers.
	logic busy_q = 1'b0; // A cipher block is in flight.

	initial
	begin
		rdata_o = 8'h00;
		done_o = 1'b0;
		result_o = '0;
	end

	// Read data stands one cycle; otherwise it toggles so stale data is never trusted.
	always @(posedge clk_i)
	begin
		if (mem_i.en && mem_i.we)
			mem[mem_i.addr] <= mem_i.wdata;
		if (mem_i.en && !mem_i.we)
			rdata_o <= mem[mem_i.addr];
		else
			rdata_o <= ~rdata_o;
	end

	// Cipher stand-in: key XOR block after lat_i cycles, result garbled outside the pulse.
	always @(posedge clk_i)
	begin
		done_o <= 1'b0;
		result_o <= ~result_o;
		if (start_i)
		begin
			busy_q <= 1'b1;
			cnt_q <= lat_i;
		end
		else if (busy_q && cnt_q <= 4'h1)
		begin
			busy_q <= 1'b0;
			done_o <= 1'b1;
			result_o <= key_i ^ din_i;
		end
		else if (busy_q)
			cnt_q <= cnt_q - 4'h1;
	end
endmodule : acci_mem_model

`default_nettype wire

// >>> sim/acci_unit_test.sv
// Self-checking bench for the security instruction engine.
`timescale 1ns/1ns
`default_nettype none

module acci_unit_test
	import acci_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic instr_valid_i = 1'b0;
	acci_instr_s instr_i = '0;
	acci_mem_req_s mem_o;
	logic [7:0] mem_rdata_i;
	logic aes_start_o;
	logic aes_done_i;
	logic [127:0] aes_key_o;
	logic [127:0] aes_din_o;
	logic [127:0] aes_result_i;
	logic busy_lo, busy_hi, done_lo, done_hi, range_err;
	logic [3:0] lat = 4'h1; // Cipher latency in cycles.
	logic [4:0] seen; // Events gathered while waiting.
	logic [7:0] snap [0:4095]; // Memory copy taken before an instruction or a group of instructions.
	int mismatches = 0;
	int tests_run = 0;

	always #10 clk_i = ~clk_i;

	acci_unit DUT (.clk_i, .rst_n_i, .instr_valid_i, .instr_i, .mem_o, .mem_rdata_i, .aes_start_o, .aes_key_o,
		.aes_din_o, .aes_done_i, .aes_result_i, .priority_slot_busy_error_lo_o(busy_lo),
		.priority_slot_busy_error_hi_o(busy_hi), .low_prio_done_event_o(done_lo),
		.high_prio_done_event_o(done_hi), .memory_range_error_o(range_err));
	acci_mem_model u_mem (.clk_i, .mem_i(mem_o), .rdata_o(mem_rdata_i), .start_i(aes_start_o), .key_i(aes_key_o),
		.din_i(aes_din_o), .lat_i(lat), .done_o(aes_done_i), .result_o(aes_result_i));

	// ==========================================================================
	// Helpers
	// ==========================================================================
	// Sixteen bytes from the snapshot, lowest address in the top byte.
	function automatic logic [127:0] blk(input int a);
		for (int i = 0; i < 16; i++)
			blk[127-8*i -: 8] = snap[a+i];
	endfunction : blk

	task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Key slot 1 and counter slot 2 throughout; returns on the taking edge.
	task automatic issue(input acci_op_e op, input logic p, input logic [6:0] c, input logic [11:0] src,
		input logic [11:0] dst, input logic [2:0] m);
		instr_valid_i <= 1'b1;
		instr_i <= '{op: op, prio: p, key_idx: 8'h01, count: c, ctr_idx: 8'h02, src: src, dst: dst, mode: m};
		@(posedge clk_i);
	endtask : issue

	// Gathers busy, range and completion events until the wanted ones have all appeared.
	task automatic wait_ev(input logic [4:0] want);
		instr_valid_i <= 1'b0;
		seen = 5'h00;
		for (int n = 0; n < 3000 && (seen & want) != want; n++)
		begin
			@(posedge clk_i);
			seen |= {busy_hi, busy_lo, range_err, done_hi, done_lo};
		end
		chk("events", 128'(want), 128'(seen));
	endtask : wait_ev

	task automatic snapshot;
		for (int i = 0; i < 4096; i++)
			snap[i] = u_mem.mem[i];
	endtask : snapshot

	task automatic chk_ctr(input logic [6:0] c, input int src, input int dst);
		logic [127:0] ks;
		logic [127:0] ct;
		for (int i = 0; i < c; i++)
		begin
			ct = blk(32);
			ct[15:0] = ct[15:0] + 16'(i / 16);
			ks = blk(16) ^ ct;
			chk("ctr byte", 128'(snap[src+i] ^ ks[127-8*(i%16) -: 8]), 128'(u_mem.mem[dst+i]));
		end
		chk("byte past end", 128'(snap[dst+c]), 128'(u_mem.mem[dst+c]));
	endtask : chk_ctr

	task automatic chk_mac(input logic [6:0] c, input int src, input int dst, input logic [2:0] m);
		logic [7:0] s [$];
		logic [127:0] ch;
		logic [127:0] b;
		int len;
		ch = '0;
		len = (m[1:0] == 2'h0) ? 0 : 2 << m[1:0];
		if (!m[2])
			s = '{8'h00, {1'b0, c}};
		for (int i = 0; i < c; i++)
			s.push_back(snap[src+i]);
		do
		begin
			b = '0;
			for (int i = 0; i < 16 && s.size() > 0; i++)
				b[127-8*i -: 8] = s.pop_front();
			ch = blk(16) ^ ch ^ b;
		end
		while (s.size() > 0);
		for (int i = 0; i < len; i++)
			chk("mac byte", 128'(ch[127-8*i -: 8]), 128'(u_mem.mem[dst+i]));
		chk("byte past code", 128'(snap[dst+len]), 128'(u_mem.mem[dst+len]));
	endtask : chk_mac

	task automatic stop_test;
		$display("Comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	initial
	begin
		for (int i = 0; i < 4096; i++)
			u_mem.mem[i] = 8'(i * 37 + 5);
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		// Counter mode over two blocks into a separate buffer, then decrypted in place at high priority.
		snapshot();
		issue(OP_CTR, 1'b0, 7'h14, 12'h100, 12'h200, 3'h0);
		wait_ev(5'h01);
		chk_ctr(7'h14, 'h100, 'h200);
		lat <= 4'h6;
		snapshot();
		issue(OP_COUNTER_DECRYPT, 1'b1, 7'h14, 12'h200, 12'h000, 3'h0);
		wait_ev(5'h02);
		chk_ctr(7'h14, 'h200, 'h200);
		// Authentication with and without the length prefix, all code lengths but none.
		snapshot();
		issue(OP_MAC, 1'b0, 7'h05, 12'h300, 12'h000, 3'h3);
		wait_ev(5'h01);
		chk_mac(7'h05, 'h300, 'h305, 3'h3);
		snapshot();
		issue(OP_MAC, 1'b1, 7'h12, 12'h300, 12'h380, 3'h5);
		wait_ev(5'h02);
		chk_mac(7'h12, 'h300, 'h380, 3'h5);
		snapshot();
		issue(OP_MAC, 1'b0, 7'h0e, 12'h300, 12'h3c0, 3'h2);
		wait_ev(5'h01);
		chk_mac(7'h0e, 'h300, 'h3c0, 3'h2);
		// Authentication without prefix and without code: nothing may be written.
		snapshot();
		issue(OP_MAC, 1'b1, 7'h03, 12'h300, 12'h3e0, 3'h4);
		wait_ev(5'h02);
		chk_mac(7'h03, 'h300, 'h3e0, 3'h4);
		// Second requests on each busy slot are refused and write nothing.
		lat <= 4'h3;
		snapshot();
		issue(OP_CTR, 1'b0, 7'h10, 12'h100, 12'h400, 3'h0);
		issue(OP_CTR, 1'b0, 7'h10, 12'h100, 12'h600, 3'h0);
		issue(OP_CTR, 1'b1, 7'h10, 12'h100, 12'h500, 3'h0);
		chk("low busy", 128'h1, 128'(busy_lo));
		issue(OP_CTR, 1'b1, 7'h10, 12'h100, 12'h700, 3'h0);
		wait_ev(5'h13);
		chk("refused low", 128'(snap['h600]), 128'(u_mem.mem['h600]));
		chk("refused high", 128'(snap['h700]), 128'(u_mem.mem['h700]));
		chk_ctr(7'h10, 'h100, 'h500);
		chk_ctr(7'h10, 'h100, 'h400);
		// Operands past the memory end: error, completion, no writes.
		snapshot();
		issue(OP_CTR, 1'b0, 7'h20, 12'hff0, 12'h800, 3'h0);
		wait_ev(5'h05);
		chk("range ctr", 128'(snap['h800]), 128'(u_mem.mem['h800]));
		issue(OP_MAC, 1'b1, 7'h04, 12'h100, 12'hffe, 3'h3);
		wait_ev(5'h06);
		chk("range mac", 128'(snap['hffe]), 128'(u_mem.mem['hffe]));
		stop_test();
	end

	// Watchdog far beyond the roughly one thousand cycles the scenarios need.
	initial
	begin
		repeat (40000) @(posedge clk_i);
		mismatches++;
		$display("Error watchdog expected finish seen timeout");
		stop_test();
	end
endmodule : acci_unit_test

bind acci_unit acci_unit_checker u_chk (.clk_i, .rst_n_i, .instr_valid_i, .instr_i, .mem_o, .aes_start_o, .aes_key_o,
	.aes_din_o, .aes_done_i,
	.priority_slot_busy_error_lo_o, .priority_slot_busy_error_hi_o, .low_prio_done_event_o, .high_prio_done_event_o,
	.memory_range_error_o);

`default_nettype wire
